// *** hw/uart_fifo_dma_defines.vh ***
/*
  Constants for the FIFO control and DMA-ready block of one UART channel:
  register byte offsets, field positions, reset values, trigger levels,
  interrupt status codes and FIFO geometry.
  Assumes inclusion by bare name from the design file; definitions only.
*/
`ifndef UART_FIFO_DMA_DEFINES_VH
`define UART_FIFO_DMA_DEFINES_VH

// ----------------------------------------------------------------------
// Register byte offsets on the APB side
// ----------------------------------------------------------------------
`define OFS_FIFO_CONTROL     8'h00
`define OFS_INTERRUPT_STATUS 8'h04
`define OFS_FIFO_LEVELS      8'h08
`define OFS_EVENT_STATUS     8'h0C
`define OFS_EVENT_CLEAR      8'h10
`define OFS_EVENT_ENABLE     8'h14
`define OFS_TRANSMIT_HOLDING 8'h18
`define OFS_RECEIVE_HOLDING  8'h1C

// ----------------------------------------------------------------------
// Field positions of fifo_control
// ----------------------------------------------------------------------
`define FC_ENABLE      0
`define FC_RX_FLUSH    1
`define FC_TX_FLUSH    2
`define FC_DMA_BLOCK   3
`define FC_TRIG_LO     6
`define FC_TRIG_HI     7
`define FC_RESET       8'h00

// ----------------------------------------------------------------------
// Receive trigger levels, selected by the two-bit trigger field
// ----------------------------------------------------------------------
`define TRIG_LEVEL_0   5'h01
`define TRIG_LEVEL_1   5'h04
`define TRIG_LEVEL_2   5'h08
`define TRIG_LEVEL_3   5'h0E

// ----------------------------------------------------------------------
// Interrupt status codes, bits 3:0
// ----------------------------------------------------------------------
`define ISR_NONE       4'h1
`define ISR_RX_LEVEL   4'h4
`define ISR_RX_TIMEOUT 4'hC
`define ISR_TX_EMPTY   4'h2

// ----------------------------------------------------------------------
// Event bit positions and FIFO geometry
// ----------------------------------------------------------------------
`define EV_TX_EMPTY    0
`define EV_RX_TRIGGER  1
`define EV_RX_TIMEOUT  2
`define EV_RX_OVERRUN  3
`define EV_RESET       4'h0
`define FIFO_DEPTH     5'h10
`define HOLD_DEPTH     5'h01

`endif

// *** hw/uart_fifo_dma_ready.v ***
/*
  FIFO control and DMA-ready pin logic for one UART channel: 16-entry
  transmit and receive FIFOs, flushes, receive trigger selection, the two
  DMA modes driving the active-low ready pins, interrupt status code and
  sticky event interrupts, all reached over an APB slave.
  Assumes one 50 MHz clock, asynchronous active-high reset, and a serial
  side that pops transmit characters and pushes received ones synchronously.
*/
// Implementation choices: the register addresses and the APB register port.
//
// Contract
// - Single mode: transmit ready low when transmit FIFO or holding register empty.
// - Single mode: transmit ready returns high once a character is written.
// - Single mode: receive ready low when a character is loaded.
// - Single mode: receive ready stays low until the receiver holds nothing.
// - Block mode: transmit ready low while any transmit location is free.
// - Block mode: transmit interrupt raised when transmit FIFO becomes empty.
// - Block mode: receive ready low at trigger or time-out, high when empty.
// - Received characters keep entering the FIFO until it is full.
// - Receive interrupt when receive count equals the selected trigger level.
// - Trigger field bits 7:6 select 1, 4, 8, 14; reset 00.
// - Control bit 3 selects single (0) or block (1) DMA mode.
// - Bit 2 flushes the transmit FIFO, then reads back zero.
// - Bit 1 flushes the receive FIFO, then reads back zero.
// - Bit 0 enables FIFOs; other bits written only when bit 0 is set.
// - Bits 5:4 unused, read zero.
// - Time-out reported as code 1100, distinct from trigger code 0100.
`timescale 1ns/1ps
`include "uart_fifo_dma_defines.vh"

module uart_fifo_dma_ready (
  input  wire        sys_clk,                  // System clock, 50 MHz.
  input  wire        rst,                      // Asynchronous reset, active high.
  input  wire        psel,                     // APB select.
  input  wire        penable,                  // APB access phase.
  input  wire        pwrite,                   // APB direction, high for write.
  input  wire [7:0]  paddr,                    // APB byte address.
  input  wire [31:0] pwdata,                   // APB write data.
  output reg  [31:0] prdata,                   // APB read data.
  output reg         pready,                   // APB ready.
  output reg         pslverr,                  // APB error for unmapped address.
  input  wire        tx_pop,                   // Serial side takes the head character.
  output reg  [7:0]  tx_data,                  // Head of the transmit FIFO.
  output reg         tx_valid,                 // Transmit FIFO holds a character.
  input  wire        rx_push,                  // Serial side delivers a character.
  input  wire [7:0]  rx_data,                  // Received character.
  input  wire        rx_timeout,               // Receive time-out pulse.
  output reg         transmit_dma_request_n,   // Transmit ready pin, active low.
  output reg         receive_dma_request_n,    // Receive ready pin, active low.
  output reg         irq                       // Level interrupt, active high.
);

  // --------------------------------------------------------------------
  // Storage and state
  // --------------------------------------------------------------------
  reg [7:0] tx_mem [0:15];
  reg [7:0] rx_mem [0:15];
  reg [3:0] tx_rd_q;
  reg [3:0] tx_wr_q;
  reg [4:0] tx_cnt_q;
  reg [3:0] rx_rd_q;
  reg [3:0] rx_wr_q;
  reg [4:0] rx_cnt_q;
  reg [7:0] fifo_control_q;
  reg [3:0] ev_status_q;
  reg [3:0] ev_enable_q;
  reg       timeout_pend_q;
  reg       tx_pend_q;
  reg       rx_block_act_q;

  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------
  wire       access   = psel & penable & pready;
  wire       wr_acc   = access & pwrite;
  wire       rd_acc   = access & ~pwrite;
  wire       sel_fc   = (paddr == `OFS_FIFO_CONTROL);
  wire       sel_isr  = (paddr == `OFS_INTERRUPT_STATUS);
  wire       sel_lvl  = (paddr == `OFS_FIFO_LEVELS);
  wire       sel_evs  = (paddr == `OFS_EVENT_STATUS);
  wire       sel_evc  = (paddr == `OFS_EVENT_CLEAR);
  wire       sel_eve  = (paddr == `OFS_EVENT_ENABLE);
  wire       sel_thr  = (paddr == `OFS_TRANSMIT_HOLDING);
  wire       sel_rhr  = (paddr == `OFS_RECEIVE_HOLDING);
  wire       mapped   = sel_fc | sel_isr | sel_lvl | sel_evs | sel_evc |
                        sel_eve | sel_thr | sel_rhr;

  // --------------------------------------------------------------------
  // Control decode
  // --------------------------------------------------------------------
  wire       fifo_en   = fifo_control_q[`FC_ENABLE];
  wire       block_dma = fifo_en & fifo_control_q[`FC_DMA_BLOCK];
  wire [4:0] capacity  = fifo_en ? `FIFO_DEPTH : `HOLD_DEPTH;
  wire       fc_write  = wr_acc & sel_fc;
  wire       en_change = fc_write & (pwdata[`FC_ENABLE] != fifo_en);

  // Flushes act only when bit 0 is set in the same write; a change of the
  // enable bit flushes both sides so the capacity never shrinks under data.
  wire       tx_flush = (fc_write & pwdata[`FC_ENABLE] & pwdata[`FC_TX_FLUSH])
                        | en_change;
  wire       rx_flush = (fc_write & pwdata[`FC_ENABLE] & pwdata[`FC_RX_FLUSH])
                        | en_change;

  // Trigger level from the two-bit field.
  reg [4:0] trig_level;
  always @* begin
    case (fifo_control_q[`FC_TRIG_HI:`FC_TRIG_LO])
      2'b00:   trig_level = `TRIG_LEVEL_0;
      2'b01:   trig_level = `TRIG_LEVEL_1;
      2'b10:   trig_level = `TRIG_LEVEL_2;
      2'b11:   trig_level = `TRIG_LEVEL_3;
      default: trig_level = `TRIG_LEVEL_0;
    endcase
  end

  // --------------------------------------------------------------------
  // FIFO traffic
  // --------------------------------------------------------------------
  wire       tx_full  = (tx_cnt_q == capacity);
  wire       rx_full  = (rx_cnt_q == capacity);
  wire       tx_push  = wr_acc & sel_thr & ~tx_full & ~tx_flush;
  wire       tx_take  = tx_pop & (tx_cnt_q != 5'h00) & ~tx_flush;
  wire       rx_take  = rd_acc & sel_rhr & (rx_cnt_q != 5'h00) & ~rx_flush;
  wire       rx_load  = rx_push & ~rx_full & ~rx_flush;
  wire       rx_ovr   = rx_push & rx_full & ~rx_flush;

  // Next occupancy counts, used so the pins follow the same edge.
  reg [4:0] tx_cnt_d;
  reg [4:0] rx_cnt_d;
  always @* begin
    if (tx_flush) begin
      tx_cnt_d = 5'h00;
    end else begin
      tx_cnt_d = tx_cnt_q + {4'h0, tx_push} - {4'h0, tx_take};
    end
    if (rx_flush) begin
      rx_cnt_d = 5'h00;
    end else begin
      rx_cnt_d = rx_cnt_q + {4'h0, rx_load} - {4'h0, rx_take};
    end
  end

  wire tx_became_empty = (tx_cnt_q != 5'h00) & (tx_cnt_d == 5'h00);
  wire rx_hit_trigger  = fifo_en & (rx_cnt_q < trig_level) &
                         (rx_cnt_d == trig_level);
  wire rx_level_on     = fifo_en & (rx_cnt_q >= trig_level);

  // Storage writes; memories need no reset.
  always @(posedge sys_clk) begin
    if (tx_push) begin
      tx_mem[tx_wr_q] <= pwdata[7:0];
    end
    if (rx_load) begin
      rx_mem[rx_wr_q] <= rx_data;
    end
  end

  // Pointers and counts; a flush resets the counter logic only, the shift
  // registers outside are untouched.
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_rd_q  <= 4'h0;
      tx_wr_q  <= 4'h0;
      tx_cnt_q <= 5'h00;
      rx_rd_q  <= 4'h0;
      rx_wr_q  <= 4'h0;
      rx_cnt_q <= 5'h00;
    end else begin
      tx_cnt_q <= tx_cnt_d;
      rx_cnt_q <= rx_cnt_d;
      if (tx_flush) begin
        tx_rd_q <= 4'h0;
        tx_wr_q <= 4'h0;
      end else begin
        if (tx_push) tx_wr_q <= tx_wr_q + 4'h1;
        if (tx_take) tx_rd_q <= tx_rd_q + 4'h1;
      end
      if (rx_flush) begin
        rx_rd_q <= 4'h0;
        rx_wr_q <= 4'h0;
      end else begin
        if (rx_load) rx_wr_q <= rx_wr_q + 4'h1;
        if (rx_take) rx_rd_q <= rx_rd_q + 4'h1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Control register
  // --------------------------------------------------------------------
  // Bit 0 is always taken; the rest only with bit 0 set. Flush bits and
  // bits 5:4 are never stored, so they read back as zero.
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fifo_control_q <= `FC_RESET;
    end else if (fc_write) begin
      fifo_control_q[`FC_ENABLE] <= pwdata[`FC_ENABLE];
      if (pwdata[`FC_ENABLE]) begin
        fifo_control_q[`FC_TRIG_HI:`FC_TRIG_LO] <=
          pwdata[`FC_TRIG_HI:`FC_TRIG_LO];
        fifo_control_q[`FC_DMA_BLOCK] <= pwdata[`FC_DMA_BLOCK];
      end
    end
  end

  // --------------------------------------------------------------------
  // Interrupt status sources
  // --------------------------------------------------------------------
  // Time-out stays pending until a character is read or the FIFO flushed;
  // transmit empty stays until status is read or the host writes data.
  // In both, a new event in the clearing cycle wins, except that a receive flush beats a time-out.
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      timeout_pend_q <= 1'b0;
      tx_pend_q      <= 1'b0;
    end else begin
      if (rx_timeout & ~rx_flush) begin
        timeout_pend_q <= 1'b1;
      end else if (rx_take | rx_flush) begin
        timeout_pend_q <= 1'b0;
      end
      if (tx_became_empty) begin
        tx_pend_q <= 1'b1;
      end else if (tx_push | (rd_acc & sel_isr)) begin
        tx_pend_q <= 1'b0;
      end
    end
  end

  // Highest pending source: time-out, then trigger level, then transmit.
  reg [3:0] isr_code;
  always @* begin
    if (timeout_pend_q) begin
      isr_code = `ISR_RX_TIMEOUT;
    end else if (rx_level_on) begin
      isr_code = `ISR_RX_LEVEL;
    end else if (tx_pend_q) begin
      isr_code = `ISR_TX_EMPTY;
    end else begin
      isr_code = `ISR_NONE;
    end
  end

  // --------------------------------------------------------------------
  // Sticky events and interrupt line
  // --------------------------------------------------------------------
  wire [3:0] ev_set;
  assign ev_set[`EV_TX_EMPTY]   = tx_became_empty;
  assign ev_set[`EV_RX_TRIGGER] = rx_hit_trigger;
  assign ev_set[`EV_RX_TIMEOUT] = rx_timeout;
  assign ev_set[`EV_RX_OVERRUN] = rx_ovr;
  wire [3:0] ev_clr = (wr_acc & sel_evc) ? pwdata[3:0] : 4'h0;
  wire [3:0] ev_next = ev_set | (ev_status_q & ~ev_clr);

  // Set beats clear in the same cycle; the enable masks the output only.
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ev_status_q <= `EV_RESET;
      ev_enable_q <= `EV_RESET;
      irq         <= 1'b0;
    end else begin
      ev_status_q <= ev_next;
      if (wr_acc & sel_eve) begin
        ev_enable_q <= pwdata[3:0];
      end
      irq <= |(ev_next & ((wr_acc & sel_eve) ? pwdata[3:0] : ev_enable_q));
    end
  end

  // --------------------------------------------------------------------
  // DMA ready pins
  // --------------------------------------------------------------------
  // Block-mode receive request latches on trigger or time-out and holds
  // until the FIFO has drained.
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_block_act_q <= 1'b0;
    end else if (rx_cnt_d == 5'h00) begin
      rx_block_act_q <= 1'b0;
    end else if ((rx_cnt_d >= trig_level) | rx_timeout) begin
      rx_block_act_q <= 1'b1;
    end
  end

  // Pins are registered from the next counts so they move on the same edge
  // as the data that causes them.
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      transmit_dma_request_n <= 1'b0;
      receive_dma_request_n  <= 1'b1;
    end else begin
      if (block_dma) begin
        transmit_dma_request_n <= (tx_cnt_d == `FIFO_DEPTH);
        if (rx_cnt_d == 5'h00) begin
          receive_dma_request_n <= 1'b1;
        end else if ((rx_cnt_d >= trig_level) | rx_timeout | rx_block_act_q) begin
          receive_dma_request_n <= 1'b0;
        end else begin
          receive_dma_request_n <= 1'b1;
        end
      end else begin
        transmit_dma_request_n <= (tx_cnt_d != 5'h00);
        receive_dma_request_n  <= (rx_cnt_d == 5'h00);
      end
    end
  end

  // --------------------------------------------------------------------
  // Serial-side transmit head
  // --------------------------------------------------------------------
  // Registered one cycle behind the pointer, so pops need a gap of a cycle.
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_data  <= 8'h00;
      tx_valid <= 1'b0;
    end else begin
      tx_data  <= tx_mem[tx_rd_q];
      tx_valid <= (tx_cnt_q != 5'h00) & ~tx_take & ~tx_flush;
    end
  end

  // --------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------
  // One wait state: pready rises in the first access cycle and the
  // transfer completes at the next edge, where writes and pops happen.
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel & penable & ~pready) begin
      pready  <= 1'b1;
      pslverr <= ~mapped;
      prdata  <= 32'h0000_0000;
      if (~pwrite) begin
        case (paddr)
          `OFS_FIFO_CONTROL:     prdata <= {24'h00_0000, fifo_control_q};
          `OFS_INTERRUPT_STATUS: prdata <= {24'h00_0000, {2{fifo_en}}, 2'b00,
                                            isr_code};
          `OFS_FIFO_LEVELS:      prdata <= {19'h0_0000, rx_cnt_q, 3'b000, tx_cnt_q};
          `OFS_EVENT_STATUS:     prdata <= {28'h000_0000, ev_status_q};
          `OFS_EVENT_ENABLE:     prdata <= {28'h000_0000, ev_enable_q};
          `OFS_RECEIVE_HOLDING:  prdata <= {24'h00_0000, rx_mem[rx_rd_q]};
          default:               prdata <= 32'h0000_0000;
        endcase
      end
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule // uart_fifo_dma_ready

// *** dv/serial_side_model.sv ***
/*
  Serial side model: delivers received characters, raises receive time-outs
  and drains the transmit FIFO on the bench's command.
  Assumes the block's clock and reset; commands arrive as bench levels.
*/
`timescale 1ns/1ps
module serial_side_model (
  input  wire       sys_clk,    // System clock.
  input  wire       rst,        // Reset, active high.
  input  wire       tx_valid,   // Transmit FIFO holds a character.
  input  wire       push_go,    // Bench asks for one received character.
  input  wire [7:0] push_byte,  // Character to deliver.
  input  wire       tmo_go,     // Bench asks for a time-out.
  input  wire       drain_en,   // Take transmit characters while set.
  output reg        tx_pop,     // Takes the head character.
  output reg        rx_push,    // Delivers a character.
  output reg  [7:0] rx_data,    // Received character, inverted when idle.
  output reg        rx_timeout  // Time-out pulse.
);
  // Never pops in the cycle after a pop; idle data keeps changing.
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_pop     <= 1'b0;
      rx_push    <= 1'b0;
      rx_data    <= 8'h00;
      rx_timeout <= 1'b0;
    end else begin
      tx_pop     <= drain_en & tx_valid & ~tx_pop;
      rx_push    <= push_go;
      rx_data    <= push_go ? push_byte : ~rx_data;
      rx_timeout <= tmo_go;
    end
  end
endmodule // serial_side_model

// *** dv/uart_fifo_dma_ready_chk.sv ***
/*
  Port checker for the FIFO control and DMA-ready block.
  Assumes one clock, one APB wait state and registered ready pins.
*/
`timescale 1ns/1ps
module uart_fifo_dma_ready_chk (
  input wire        sys_clk,                 // Clock.
  input wire        rst,                     // Reset.
  input wire        psel,                    // APB select.
  input wire        penable,                 // APB enable.
  input wire        pwrite,                  // APB direction.
  input wire [7:0]  paddr,                   // APB address.
  input wire [31:0] pwdata,                  // APB write data.
  input wire [31:0] prdata,                  // APB read data.
  input wire        pready,                  // APB ready.
  input wire        pslverr,                 // APB error.
  input wire        tx_pop,                  // Transmit pop.
  input wire        tx_valid,                // Transmit not empty.
  input wire        rx_push,                 // Receive push.
  input wire        rx_timeout,              // Time-out pulse.
  input wire        transmit_dma_request_n,  // Transmit ready pin.
  input wire        receive_dma_request_n,   // Receive ready pin.
  input wire        irq                      // Interrupt.
);
  wire done = psel & penable & pready;
  reg  en_q;
  reg  dma_q;
  wire blk = en_q & dma_q;

  // Shadow of the enable and mode bits; mode is kept only with enable set.
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      en_q  <= 1'b0;
      dma_q <= 1'b0;
    end else if (done & pwrite & (paddr == 8'h00)) begin
      en_q <= pwdata[0];
      if (pwdata[0]) dma_q <= pwdata[3];
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
  wait_state_a: assert property (psel && penable && !$past(penable) |=> pready)
    else $error("pready not one cycle after access");
  slverr_addr_a: assert property (done && paddr > 8'h1C |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  reset_out_a: assert property ($fell(rst) |-> receive_dma_request_n && !transmit_dma_request_n
    && !irq && !tx_valid) else $error("outputs wrong after reset");
  rx_load_a: assert property (rx_push && !blk && !done |=> !receive_dma_request_n)
    else $error("receive pin not low after load");
  thr_write_a: assert property (done && pwrite && paddr == 8'h18 && !blk && !tx_pop
    |=> transmit_dma_request_n) else $error("transmit pin not high after write");
  tmo_block_a: assert property (rx_timeout && blk && !done |=> !receive_dma_request_n)
    else $error("receive pin not low after time-out");
  rx_release_a: assert property ($rose(receive_dma_request_n) |-> $past(done))
    else $error("receive pin released without a read or flush");
  tx_assert_a: assert property ($fell(transmit_dma_request_n) |-> $past(tx_pop) || $past(done))
    else $error("transmit pin fell without a pop or flush");
  full_block_a: assert property (blk && $past(blk) && transmit_dma_request_n
    && $past(transmit_dma_request_n) |-> tx_valid) else $error("full pin with empty FIFO");
  pop_valid_a: assert property (tx_pop && tx_valid |=> !tx_valid)
    else $error("valid not low after pop");
endmodule // uart_fifo_dma_ready_chk

bind uart_fifo_dma_ready uart_fifo_dma_ready_chk chk_u (.sys_clk(sys_clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_pop(tx_pop),
  .tx_valid(tx_valid), .rx_push(rx_push), .rx_timeout(rx_timeout), .irq(irq),
  .transmit_dma_request_n(transmit_dma_request_n), .receive_dma_request_n(receive_dma_request_n));

// *** dv/uart_fifo_control_dma_ready_test.sv ***
/*
  Self-checking bench: APB host tasks, trigger-level table, hand-written cases.
  Assumes the design, the serial side model and the checker compiled first.
*/
`timescale 1ns/1ps
`include "uart_fifo_dma_defines.vh"
module uart_fifo_control_dma_ready_test;
  reg         sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg         push_go = 1'b0, tmo_go = 1'b0, drain_en = 1'b0, err_q;
  reg  [7:0]  paddr = 8'h00, push_byte = 8'h00, fcw;
  reg  [31:0] pwdata = 32'h0, rd_q;
  reg  [19:0] rows [0:3];
  wire [31:0] prdata;
  wire [7:0]  tx_data, rx_data;
  wire        pready, pslverr, tx_pop, tx_valid, rx_push, rx_timeout, irq;
  wire        transmit_dma_request_n, receive_dma_request_n;
  integer     n_mismatch = 0, samples_checked = 0, i, k, lvl;

  always #10 sys_clk = ~sys_clk;

  uart_fifo_dma_ready dut_u (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_pop(tx_pop), .tx_data(tx_data), .tx_valid(tx_valid),
    .rx_push(rx_push), .rx_data(rx_data), .rx_timeout(rx_timeout), .irq(irq),
    .transmit_dma_request_n(transmit_dma_request_n), .receive_dma_request_n(receive_dma_request_n));
  serial_side_model far_u (.sys_clk(sys_clk), .rst(rst), .tx_valid(tx_valid), .push_go(push_go),
    .push_byte(push_byte), .tmo_go(tmo_go), .drain_en(drain_en), .tx_pop(tx_pop),
    .rx_push(rx_push), .rx_data(rx_data), .rx_timeout(rx_timeout));

  // Compares and counts; a mismatch prints at once.
  task chk(input [31:0] got, input [31:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; the request holds until pready is sampled high.
  task apb(input w, input [7:0] a, input [31:0] d);
    integer n;
    @(posedge sys_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n = n + 1;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk(32'h0, 32'h1);
    rd_q    = prdata;
    err_q   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input [7:0] a, input [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_q, exp);
  endtask
  task push(input [7:0] b);
    @(posedge sys_clk);
    push_go   <= 1'b1;
    push_byte <= b;
    @(posedge sys_clk);
    push_go   <= 1'b0;
  endtask
  task settle;
    repeat (3) @(posedge sys_clk);
  endtask
  // Pins as {transmit, receive}.
  task pins(input [1:0] e);
    chk({30'h0, transmit_dma_request_n, receive_dma_request_n}, {30'h0, e});
  endtask
  task stop_test;
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Watchdog cuts a hang short.
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch = n_mismatch + 1;
    stop_test;
  end

  // Table rows: control written, control read back, trigger level.
  initial begin
    rows[0] = {8'h01, 8'h01, 4'h1};
    rows[1] = {8'h47, 8'h41, 4'h4};
    rows[2] = {8'h8F, 8'h89, 4'h8};
    rows[3] = {8'hF1, 8'hC1, 4'hE};
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    pins(2'b01);
    rd(`OFS_FIFO_CONTROL, 32'h0);
    wr(`OFS_EVENT_ENABLE, 32'hF);
    for (i = 0; i < 4; i = i + 1) begin
      fcw = rows[i][19:12];
      lvl = rows[i][3:0];
      wr(`OFS_FIFO_CONTROL, {24'h0, fcw | 8'h06});
      rd(`OFS_FIFO_CONTROL, {24'h0, rows[i][11:4]});
      wr(`OFS_EVENT_CLEAR, 32'hF);
      for (k = 1; k <= lvl + 1; k = k + 1) begin
        if (k == lvl) begin
          settle;
          apb(1'b0, `OFS_EVENT_STATUS, 32'h0);
          chk(rd_q & 32'h2, 32'h0);
          pins({1'b0, lvl == 1 || fcw[3]});
        end
        push(k[7:0]);
      end
      settle;
      apb(1'b0, `OFS_EVENT_STATUS, 32'h0);
      chk(rd_q & 32'h2, 32'h2);
      rd(`OFS_INTERRUPT_STATUS, 32'hC4);
      chk({31'h0, irq}, 32'h1);
      pins(2'b00);
      for (k = 1; k <= lvl + 1; k = k + 1) rd(`OFS_RECEIVE_HOLDING, k);
      settle;
      pins(2'b01);
    end
    // Enable low in the write: only the enable bit changes; FIFOs hold one.
    wr(`OFS_FIFO_CONTROL, 32'hC8);
    rd(`OFS_FIFO_CONTROL, 32'hC0);
    push(8'h5A);
    push(8'hA5);
    wr(`OFS_TRANSMIT_HOLDING, 32'h33);
    settle;
    pins(2'b10);
    chk({24'h0, tx_data}, 32'h33);
    rd(`OFS_FIFO_LEVELS, 32'h101);
    rd(`OFS_RECEIVE_HOLDING, 32'h5A);
    settle;
    pins(2'b11);
    drain_en <= 1'b1;
    k = 0;
    while (transmit_dma_request_n !== 1'b0 && k < 40) begin
      @(posedge sys_clk);
      k = k + 1;
    end
    pins(2'b01);
    // Block mode: fill the transmit FIFO to the brim, then drain it.
    drain_en <= 1'b0;
    wr(`OFS_FIFO_CONTROL, 32'h0F);
    wr(`OFS_EVENT_ENABLE, 32'h0);
    for (k = 0; k < 15; k = k + 1) wr(`OFS_TRANSMIT_HOLDING, k);
    settle;
    pins(2'b01);
    wr(`OFS_TRANSMIT_HOLDING, 32'h0F);
    settle;
    pins(2'b11);
    wr(`OFS_TRANSMIT_HOLDING, 32'h10);
    rd(`OFS_FIFO_LEVELS, 32'h10);
    wr(`OFS_EVENT_CLEAR, 32'hF);
    drain_en <= 1'b1;
    k = 0;
    do begin
      apb(1'b0, `OFS_FIFO_LEVELS, 32'h0);
      k = k + 1;
    end while (rd_q[4:0] !== 5'h00 && k < 40);
    drain_en <= 1'b0;
    settle;
    apb(1'b0, `OFS_EVENT_STATUS, 32'h0);
    chk(rd_q & 32'h1, 32'h1);
    rd(`OFS_INTERRUPT_STATUS, 32'hC2);
    rd(`OFS_INTERRUPT_STATUS, 32'hC1);
    chk({31'h0, irq}, 32'h0);
    wr(`OFS_EVENT_ENABLE, 32'h1);
    settle;
    chk({31'h0, irq}, 32'h1);
    wr(`OFS_EVENT_CLEAR, 32'h1);
    settle;
    chk({31'h0, irq}, 32'h0);
    // Time-out below the trigger level in block mode.
    wr(`OFS_FIFO_CONTROL, 32'h4B);
    push(8'h77);
    settle;
    pins(2'b01);
    tmo_go <= 1'b1;
    @(posedge sys_clk);
    tmo_go <= 1'b0;
    settle;
    pins(2'b00);
    rd(`OFS_INTERRUPT_STATUS, 32'hCC);
    rd(`OFS_RECEIVE_HOLDING, 32'h77);
    settle;
    pins(2'b01);
    // Flushes with data held on both sides empty both FIFOs.
    push(8'h11);
    wr(`OFS_TRANSMIT_HOLDING, 32'h22);
    wr(`OFS_FIFO_CONTROL, 32'h4F);
    rd(`OFS_FIFO_LEVELS, 32'h0);
    // Unmapped address is refused.
    apb(1'b0, 8'h20, 32'h0);
    chk(rd_q, 32'h0);
    chk({31'h0, err_q}, 32'h1);
    stop_test;
  end
endmodule // uart_fifo_control_dma_ready_test
